// File: verilog/dbt_pkg.sv
// Purpose: constants for the dual byte split timer
// Assumes: 8-bit counters, four channels per counter
// Notes:   prescaler select codes are a small power-of-two set
package dbt_pkg;
    localparam int CNT_W        = 8;
    localparam int NUM_CH       = 4;
    localparam int PRE_W        = 3;
    localparam int PRE_CNT_W    = 10;
    localparam logic [7:0] CNT_RST   = 8'h00;
    localparam logic [7:0] PER_RST   = 8'hFF;
    localparam logic [7:0] CNT_ZERO  = 8'h00;
    localparam logic [9:0] PRE_ZERO  = 10'h000;
    localparam logic [9:0] PRE_ONE   = 10'h001;
    typedef enum logic [1:0] {
        DBT_SRC_OFF = 2'b00,
        DBT_SRC_PRE = 2'b01,
        DBT_SRC_EVT = 2'b11
    } dbt_src_e;
endpackage : dbt_pkg

// File: verilog/dbt_dual_byte_split_timer.sv
// Purpose: split-mode timer, two 8-bit down counters, eight pwm outputs
// Assumes: all inputs synchronous to clk
// Notes:   pwm output high while count is below compare value
`timescale 1ns/1ps
module dbt_dual_byte_split_timer
    import dbt_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic [1:0]               clkSrc,
    input  wire logic [PRE_W-1:0]         preSel,
    input  wire logic                     evtCount,
    input  wire logic [CNT_W-1:0]         perLo,
    input  wire logic [CNT_W-1:0]         perHi,
    input  wire logic [NUM_CH*CNT_W-1:0]  cmpLo,
    input  wire logic [NUM_CH*CNT_W-1:0]  cmpHi,
    input  wire logic [NUM_CH-1:0]        cmpFlagClr,
    input  wire logic [1:0]               unfFlagClr,
    output logic      [CNT_W-1:0]         cntLo,
    output logic      [CNT_W-1:0]         cntHi,
    output logic      [2*NUM_CH-1:0]      pwmOut,
    output logic      [NUM_CH-1:0]        cmpFlagLo,
    output logic      [NUM_CH-1:0]        cmpEvtLo,
    output logic      [NUM_CH-1:0]        cmpDmaLo,
    output logic      [1:0]               unfFlag,
    output logic      [1:0]               unfEvt,
    output logic                          unfDmaLo
);
    logic [PRE_CNT_W-1:0] preCnt_q;
    logic [PRE_CNT_W-1:0] preLimit;
    logic                 preTick;
    logic                 tick;
    logic [CNT_W-1:0]     cntLo_q;
    logic [CNT_W-1:0]     cntHi_q;
    logic [NUM_CH-1:0]    hitLo;
    logic [2*NUM_CH-1:0]  pwm_q;
    logic [NUM_CH-1:0]    cmpFlag_q;
    logic [NUM_CH-1:0]    cmpEvt_q;
    logic [1:0]           unfFlag_q;
    logic [1:0]           unfEvt_q;

    // prescaler: divide by 2**preSel, a one-cycle enable
    assign preLimit = PRE_CNT_W'(PRE_ONE << preSel);
    // compare with >= so lowering preSel never strands the count
    assign preTick  = (preCnt_q >= preLimit - PRE_ONE);
    always_ff @(posedge clk) begin
        if (!resetn || clkSrc != DBT_SRC_PRE || preTick) begin
            preCnt_q <= PRE_ZERO;
        end else begin
            preCnt_q <= preCnt_q + PRE_ONE;
        end
    end

    always_comb begin
        case (clkSrc)
            DBT_SRC_PRE: tick = preTick;
            DBT_SRC_EVT: tick = evtCount;
            default:     tick = 1'b0;
        endcase
    end

    // both counters share tick; each reloads its own period
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cntLo_q <= CNT_RST;
        end else if (tick) begin
            if (cntLo_q == CNT_ZERO) begin
                cntLo_q <= perLo;
            end else begin
                cntLo_q <= cntLo_q - 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cntHi_q <= CNT_RST;
        end else if (tick) begin
            if (cntHi_q == CNT_ZERO) begin
                cntHi_q <= perHi;
            end else begin
                cntHi_q <= cntHi_q - 8'h01;
            end
        end
    end

    // match on the tick that loads the compare value
    always_comb begin
        for (int n = 0; n < NUM_CH; n++) begin
            hitLo[n] = tick &&
                (cntLo_q - 8'h01) == cmpLo[n*CNT_W +: CNT_W] &&
                cntLo_q != CNT_ZERO;
        end
    end

    // registered pwm: high while count below compare
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pwm_q <= '0;
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                pwm_q[n] <=
                    cntLo_q < cmpLo[n*CNT_W +: CNT_W];
                pwm_q[n+NUM_CH] <=
                    cntHi_q < cmpHi[n*CNT_W +: CNT_W];
            end
        end
    end

    // only the low counter feeds compare flags, events and dma; set wins clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmpFlag_q <= '0;
            cmpEvt_q  <= '0;
        end else begin
            cmpFlag_q <= (cmpFlag_q & ~cmpFlagClr) | hitLo;
            cmpEvt_q  <= hitLo;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            unfFlag_q <= '0;
            unfEvt_q  <= '0;
        end else begin
            unfEvt_q  <= {tick && cntHi_q == CNT_ZERO,
                          tick && cntLo_q == CNT_ZERO};
            unfFlag_q <= (unfFlag_q & ~unfFlagClr) |
                         {tick && cntHi_q == CNT_ZERO,
                          tick && cntLo_q == CNT_ZERO};
        end
    end

    assign cntLo     = cntLo_q;
    assign cntHi     = cntHi_q;
    assign pwmOut    = pwm_q;
    assign cmpFlagLo = cmpFlag_q;
    assign cmpEvtLo  = cmpEvt_q;
    assign cmpDmaLo  = cmpEvt_q;
    assign unfFlag   = unfFlag_q;
    assign unfEvt    = unfEvt_q;
    assign unfDmaLo  = unfEvt_q[0];

    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);

    lo_down_a: assert property (
        tick && cntLo_q != CNT_ZERO |=> cntLo_q == $past(cntLo_q) - 8'h01)
        else $error("low not down");
    hi_down_a: assert property (
        tick && cntHi_q != CNT_ZERO |=> cntHi_q == $past(cntHi_q) - 8'h01)
        else $error("high not down");
    lo_reload_a: assert property (
        tick && cntLo_q == CNT_ZERO |=> cntLo_q == $past(perLo))
        else $error("low no reload");
    hi_reload_a: assert property (
        tick && cntHi_q == CNT_ZERO |=> cntHi_q == $past(perHi))
        else $error("high no reload");
    hold_notick_a: assert property (
        !tick |=> $stable(cntLo_q) && $stable(cntHi_q))
        else $error("count without tick");
    evt_src_a: assert property (
        clkSrc == DBT_SRC_EVT && !evtCount |=> $stable(cntLo_q))
        else $error("event tick bad");
    evt_tick_a: assert property (
        clkSrc == DBT_SRC_EVT && evtCount && cntHi_q != CNT_ZERO |=>
        cntHi_q != $past(cntHi_q))
        else $error("event pulse lost");
    src_off_a: assert property (
        clkSrc != DBT_SRC_PRE && clkSrc != DBT_SRC_EVT |=>
        $stable(cntLo_q) && $stable(cntHi_q))
        else $error("count while source off");
    pre_range_a: assert property (
        clkSrc == DBT_SRC_PRE && $stable(preSel) |-> preCnt_q < preLimit)
        else $error("prescaler past wrap");
    pre_div_a: assert property (
        clkSrc == DBT_SRC_PRE && preSel == 3'h1 && tick ##1
        clkSrc == DBT_SRC_PRE && $stable(preSel) |-> !tick)
        else $error("divide by two broken");
    pwm_lo_a: assert property (
        cntLo_q >= cmpLo[CNT_W-1:0] |=> !pwmOut[0])
        else $error("low pwm wrong");
    pwm_hi_a: assert property (
        cntHi_q < cmpHi[CNT_W-1:0] |=> pwmOut[NUM_CH])
        else $error("high pwm wrong");
    pwm_lo3_a: assert property (
        cntLo_q < cmpLo[3*CNT_W +: CNT_W] |=> pwmOut[NUM_CH-1])
        else $error("low pwm three wrong");
    pwm_hi3_a: assert property (
        cntHi_q >= cmpHi[3*CNT_W +: CNT_W] |=> !pwmOut[2*NUM_CH-1])
        else $error("high pwm three wrong");
    cmp_evt_a: assert property (
        hitLo[0] |=> cmpEvtLo[0] && cmpFlagLo[0] && cmpDmaLo[0])
        else $error("compare event missing");
    cmp_evt3_a: assert property (
        hitLo[3] |=> cmpEvtLo[3] && cmpFlagLo[3] && cmpDmaLo[3])
        else $error("compare three missing");
    evt_pulse_a: assert property (
        !hitLo[1] |=> !cmpEvtLo[1] && !cmpDmaLo[1])
        else $error("stray compare event");
    hi_quiet_a: assert property (
        tick && cntHi_q - 8'h01 == cmpHi[CNT_W-1:0] &&
        cntHi_q != CNT_ZERO && !hitLo[0] |=> !cmpEvtLo[0] && !cmpDmaLo[0])
        else $error("high match raised event");
    set_wins_a: assert property (
        hitLo[2] && cmpFlagClr[2] |=> cmpFlagLo[2])
        else $error("clear beat set");
    flag_clr_a: assert property (
        cmpFlagClr[1] && !hitLo[1] |=> !cmpFlagLo[1])
        else $error("compare flag stuck");
    unf_flag_a: assert property (
        tick && cntLo_q == CNT_ZERO |=> unfFlag[0] && unfEvt[0])
        else $error("underflow missed");
    unf_hi_a: assert property (
        tick && cntHi_q == CNT_ZERO |=> unfFlag[1] && unfEvt[1])
        else $error("high underflow missed");
    unf_dma_a: assert property (
        tick && cntLo_q == CNT_ZERO |=> unfDmaLo)
        else $error("underflow dma missed");
    unf_clr_a: assert property (
        unfFlagClr[1] && !(tick && cntHi_q == CNT_ZERO) |=> !unfFlag[1])
        else $error("underflow flag stuck");

    reload_c: cover property (tick && cntLo_q == CNT_ZERO);
    match_c:  cover property (hitLo[3]);
    evt_c:    cover property (clkSrc == DBT_SRC_EVT && evtCount);
    pwm_c:    cover property ($rose(pwmOut[NUM_CH+1]));
    pre_c:    cover property (
        clkSrc == DBT_SRC_PRE && preSel != 3'h0 && tick);
endmodule : dbt_dual_byte_split_timer

// File: bench/dbt_evt_source.sv
// Purpose: event system model, sends count pulses
// Assumes: pulses may come back to back
// Notes:   lfsr pattern, so gaps vary without a seed
`timescale 1ns/1ps
module dbt_evt_source (
    input  wire logic clk,
    input  wire logic enable,
    output logic      evtCount
);
    logic [7:0] lfsr_q = 8'hA5;
    initial evtCount = 1'b0;
    always @(posedge clk) begin
        lfsr_q   <= #1 {lfsr_q[6:0], ^(lfsr_q & 8'hB8)};
        evtCount <= #1 enable & lfsr_q[0];
    end
endmodule : dbt_evt_source

// File: bench/tb_top.sv
// Purpose: self-checking bench for the split timer
// Assumes: prescale select follows the test index, so divides vary
// Notes:   reference state steps at each rising edge
`timescale 1ns/1ps
module tb_top;
    import dbt_pkg::*;
    logic        clk, resetn, evt, ud;
    logic [1:0]  src, ufc, ue, uf, eu, euf;
    logic [2:0]  pre;
    logic [7:0]  pL, pH, cL, cH, eL, eH, pw, ep;
    logic [31:0] mL, mH;
    logic [3:0]  cfc, cf, ce, cd, ef, ee;
    int          failures, samplesChecked;
    dbt_dual_byte_split_timer dbt_dual_byte_split_timer_inst (.clk(clk),
        .resetn(resetn), .clkSrc(src), .preSel(pre), .evtCount(evt),
        .perLo(pL), .perHi(pH), .cmpLo(mL), .cmpHi(mH),
        .cmpFlagClr(cfc), .unfFlagClr(ufc), .cntLo(cL), .cntHi(cH),
        .pwmOut(pw), .cmpFlagLo(cf), .cmpEvtLo(ce), .cmpDmaLo(cd),
        .unfFlag(uf), .unfEvt(ue), .unfDmaLo(ud));
    dbt_evt_source dbt_evt_source_inst (.clk(clk), .enable(src[1]),
        .evtCount(evt));
    function automatic logic [7:0] nxt(input logic [7:0] c, p);
        return (c == 8'h00) ? p : c - 8'h01;
    endfunction : nxt
    always @(posedge clk) begin : model
        logic t, tp;
        logic [9:0] pc;
        tp = pc >= (10'h001 << pre) - 10'h001;
        t = (src == 2'b11) ? evt : (src == 2'b01) && tp;
        pc = (!resetn || src != 2'b01 || tp) ? 10'h000 : pc + 10'h001;
        for (int n = 0; n < 4; n++) begin
            ep[n] = eL < mL[8*n+:8];
            ep[n+4] = eH < mH[8*n+:8];
            ee[n] = t && eL != 8'h00 && eL - 8'h01 == mL[8*n+:8];
        end
        eu = {t && eH == 8'h00, t && eL == 8'h00};
        ef = ee | (ef & ~cfc);
        euf = eu | (euf & ~ufc);
        if (t) eL = nxt(eL, pL);
        if (t) eH = nxt(eH, pH);
        if (!resetn) {eL, eH, ep, ee, ef, eu, euf} = '0;
    end
    task automatic chk(input string n, input logic [7:0] e, s);
        samplesChecked++;
        if (e !== s) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic run(input int cyc, input logic [1:0] s, input bit rnd);
        repeat (cyc) begin
            @(posedge clk);
            #1;
            chk("cntLo", eL, cL);
            chk("cntHi", eH, cH);
            chk("pwmOut", ep, pw);
            chk("cmpEvtFlag", {ee, ef}, {ce, cf});
            chk("cmpDma", {4'h0, ee}, {4'h0, cd});
            chk("unf", {3'h0, eu[0], eu, euf}, {3'h0, ud, ue, uf});
            src = s;
            cfc = ($urandom_range(3) == 0) ? 4'($urandom) : 4'h0;
            ufc = ($urandom_range(3) == 0) ? 2'($urandom) : 2'h0;
            if (rnd && $urandom_range(15) == 0) begin
                {pL, pH} = 16'($urandom);
                mL = $urandom;
                mH = $urandom;
            end
        end
        $display("test done source %b random %0d", s, rnd);
    endtask : run
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        failures++;
        results();
    end
    initial begin
        {resetn, src, pre, cfc, ufc} = '0;
        {pL, pH, mL, mH} = {16'h0305, 32'hFF02_0100, 32'h0006_0304};
        void'($urandom(32'h80048189));
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        run(40, 2'b01, 1'b0);
        run(60, 2'b11, 1'b0);
        for (int k = 0; k < 8; k++) begin
            pre = 3'(k);
            run(200, 2'(k), 1'b1);
        end
        {resetn, pre} = '0;
        run(3, 2'b01, 1'b0);
        resetn = 1'b1;
        run(20, 2'b01, 1'b0);
        results();
    end
endmodule : tb_top
